// ---- tb/ctl_model.sv ----
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// Controller that issues control states
// ----------------------------------------------------------------------
module ctl_model
  import cam_ctl_pkg::*;
(
  input  wire logic          clock_i,
  output logic      [11:0]   op_o,
  output logic               write_n_o,
  output logic               address_valid_n_o,
  output logic               half_select_o,
  output logic      [DW-1:0] dq_o
);
  initial begin
    op_o = 12'h000;
    write_n_o = 1'b1;
    address_valid_n_o = 1'b0;
    half_select_o = 1'b0;
    dq_o = 32'h00000000;
  end

  // Callers pass documented op constants, once with upper op bits 2a. A low qual
  // leaves address valid low, which only a scenario about ignored states asks for.
  task automatic issue(input logic [11:0] op, input logic wn,
                       input logic [DW-1:0] d, input logic qual);
    @(posedge clock_i);
    op_o <= op;
    write_n_o <= wn;
    dq_o <= d;
    half_select_o <= 1'b0;
    address_valid_n_o <= qual;
    @(posedge clock_i);
    address_valid_n_o <= 1'b0;
    write_n_o <= 1'b1;
    op_o <= ~op;
    dq_o <= ~d;
  endtask
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/10ps
module tb
  import cam_ctl_pkg::*;
;
  logic            clock_i = 1'b0;
  logic            rst_i = 1'b1;
  logic [11:0]     op;
  logic            wn, av, hs;
  logic [DW-1:0]   dq;
  logic            full_in_n = 1'b0;
  logic            top_in_n = 1'b0;
  logic [NLOC-1:0] match_vec = '0;
  logic [AW-1:0]   top_addr = 13'h0000;
  logic            top_hit = 1'b0;
  logic            match_n = 1'b1;
  logic            multi_n = 1'b1;
  logic            cmp_done = 1'b0;
  logic [3:0]      reg_addr = 4'h0;
  logic [DW-1:0]   reg_wdata = 32'h00000000;
  logic            reg_wr = 1'b0;
  logic            reg_rd = 1'b0;
  logic [DW-1:0]   rdata, dq_out, v;
  logic            dq_oe, full_n, sreset;
  logic [RW-1:0]   page;
  logic [AW-1:0]   active;
  int              errors = 0;
  int              check_count = 0;
  int              cycles = 0;

  always #25 clock_i = ~clock_i;

  ctl_model ctl (.clock_i(clock_i), .op_o(op), .write_n_o(wn),
    .address_valid_n_o(av), .half_select_o(hs), .dq_o(dq));

  cam_validity_init_control dut (.clock_i(clock_i), .rst_i(rst_i),
    .op_i(op), .write_n_i(wn), .address_valid_n_i(av),
    .half_select_i(hs), .dq_i(dq), .full_in_n_i(full_in_n),
    .top_match_in_n_i(top_in_n), .match_vec_i(match_vec),
    .top_match_addr_i(top_addr), .top_match_hit_i(top_hit),
    .match_n_i(match_n), .multi_match_n_i(multi_n),
    .compare_done_i(cmp_done), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(rdata), .dq_o(dq_out), .dq_oe_o(dq_oe),
    .full_flag_n_o(full_n), .page_o(page), .active_o(active),
    .soft_reset_o(sreset));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic complete_run;
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock_i);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock_i);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock_i);
    reg_rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic do_op(input logic [5:0] c);
    ctl.issue({6'h00, c}, 1'b0, 32'h00000000, 1'b1);
  endtask

  task automatic val_read(input logic [31:0] exp);
    ctl.issue({6'h00, OP_MARK_VALID}, 1'b1, 32'h00000000, 1'b1);
    #1 check({31'h0, dq_oe}, 32'h1);
    check(dq_out, exp);
  endtask

  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      errors++;
      complete_run;
    end
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    #1 check({27'h0, page, full_n}, {27'h0, 4'hf, 1'b1});
    check({19'h0, active}, 32'h00001fff);
    reg_read(OFF_STATUS, v);
    check(v, 32'h730f1fff);
    reg_read(OFF_SETUP, v);
    check(v, SETUP_HW_RST);
    reg_read(OFF_UNIT, v);
    check(v, UNIT_HW_RST);
    reg_read(4'h2, v);
    check(v, 32'h00000000);
    val_read(32'h1);
    ctl.issue({6'h2a, OP_MARK_VALID}, 1'b0, 32'h0, 1'b1);
    val_read(32'h0);
    ctl.issue({6'h00, OP_MARK_EMPTY}, 1'b0, 32'h0, 1'b0);
    val_read(32'h0);
    do_op(OP_MARK_EMPTY);
    val_read(32'h1);
    reg_write(OFF_POINTER, 32'h5);
    do_op(OP_STEP_UP);
    reg_read(OFF_POINTER, v);
    check(v, 32'h6);
    do_op(OP_STEP_DOWN);
    do_op(OP_STEP_DOWN);
    reg_read(OFF_POINTER, v);
    check(v, 32'h4);
    do_op(OP_MARK_VALID);
    match_vec[4] <= 1'b1;
    do_op(OP_EMPTY_ALL);
    val_read(32'h1);
    match_vec <= '0;
    do_op(OP_MARK_VALID);
    top_addr <= 13'h0004;
    top_hit <= 1'b1;
    top_in_n <= 1'b1;
    do_op(OP_EMPTY_TOP);
    val_read(32'h1);
    match_n <= 1'b0;
    cmp_done <= 1'b1;
    @(posedge clock_i);
    cmp_done <= 1'b0;
    reg_read(OFF_STATUS, v);
    check(v & 32'h73000000, 32'h30000000);
    match_n <= 1'b1;
    // Rank loads are how a cascade without select lines gets numbered.
    ctl.issue({6'h00, OP_LOAD_RANK}, 1'b0, 32'h5, 1'b1);
    @(posedge clock_i);
    #1 check({31'h0, full_n}, 32'h0);
    reg_read(OFF_SETUP, v);
    check(v, {SETUP_HW_RST[31:4], 4'h5});
    do_op(OP_CLEAR_FULL);
    @(posedge clock_i);
    #1 check({31'h0, full_n}, 32'h1);
    // A load is refused while an upstream device still has room.
    full_in_n <= 1'b1;
    ctl.issue({6'h00, OP_LOAD_RANK}, 1'b0, 32'h9, 1'b1);
    reg_read(OFF_SETUP, v);
    check(v, {SETUP_HW_RST[31:4], 4'h5});
    full_in_n <= 1'b0;
    reg_write(OFF_UNIT, 32'h00000003);
    do_op(OP_STEP_UP);
    reg_read(OFF_POINTER, v);
    check(v, 32'h4);
    reg_write(OFF_UNIT, 32'h00000005);
    do_op(OP_STEP_UP);
    reg_read(OFF_POINTER, v);
    check(v, 32'h5);
    do_op(OP_MARK_VALID);
    do_op(OP_SOFT_RESET);
    #1 check({31'h0, sreset}, 32'h1);
    check({15'h0, page, active}, {15'h0, 4'hf, 13'h1fff});
    reg_read(OFF_STATUS, v);
    check(v, 32'h730f1fff);
    reg_read(OFF_SETUP, v);
    check(v, {SETUP_HW_RST[31:4], 4'h5});
    reg_read(OFF_UNIT, v);
    check(v, 32'h00000105);
    reg_read(OFF_POINTER, v);
    check(v, 32'h0);
    val_read(32'h1);
    do_op(OP_STEP_DOWN);
    reg_read(OFF_POINTER, v);
    check(v, 32'h00001fff);
    complete_run;
  end
endmodule

// ---- verilog/cam_ctl_pkg.sv ----
package cam_ctl_pkg;

  localparam int AW   = 13;
  localparam int NLOC = 8192;
  localparam int DW   = 32;
  localparam int RW   = 4;
  localparam int OPW  = 6;

  localparam logic [OPW-1:0] OP_MARK_VALID = 6'h20;
  localparam logic [OPW-1:0] OP_MARK_EMPTY = 6'h21;
  localparam logic [OPW-1:0] OP_EMPTY_TOP  = 6'h22;
  localparam logic [OPW-1:0] OP_EMPTY_ALL  = 6'h23;
  localparam logic [OPW-1:0] OP_STEP_UP    = 6'h24;
  localparam logic [OPW-1:0] OP_STEP_DOWN  = 6'h25;
  localparam logic [OPW-1:0] OP_LOAD_RANK  = 6'h3c;
  localparam logic [OPW-1:0] OP_CLEAR_FULL = 6'h3d;
  localparam logic [OPW-1:0] OP_SOFT_RESET = 6'h3f;

  localparam logic [3:0] OFF_SETUP   = 4'h0;
  localparam logic [3:0] OFF_STATUS  = 4'h4;
  localparam logic [3:0] OFF_UNIT    = 4'h8;
  localparam logic [3:0] OFF_POINTER = 4'hc;

  localparam logic [1:0] TYPE_MATCH  = 2'h0;
  localparam logic [1:0] TYPE_MEMORY = 2'h1;
  localparam logic [1:0] TYPE_RESET  = 2'h3;

  localparam logic [RW-1:0] PAGE_ONES   = 4'hf;
  localparam logic [AW-1:0] ACTIVE_ONES = 13'h1fff;
  localparam logic [AW-1:0] ACTIVE_4K   = 13'h0fff;
  localparam logic [AW-1:0] PTR_RST     = 13'h0000;
  localparam logic [AW-1:0] PTR_ONE     = 13'h0001;

  typedef struct packed {
    logic [2:0]    mask_src;
    logic          rsvd28;
    logic [1:0]    mode;
    logic          lowest_rank;
    logic [20:0]   rsvd;
    logic [RW-1:0] rank;
  } setup_t;

  typedef struct packed {
    logic [22:0]   rsvd;
    logic          sel_dis;
    logic [3:0]    rsvd7;
    logic [RW-1:0] unit;
  } unit_sel_t;

  typedef struct packed {
    logic          rsvd31;
    logic          match_n;
    logic          multi_n;
    logic          full_n;
    logic [1:0]    rsvd27;
    logic [1:0]    addr_type;
    logic [3:0]    rsvd23;
    logic [RW-1:0] page;
    logic [2:0]    rsvd15;
    logic [AW-1:0] active;
  } status_t;

  localparam setup_t SETUP_HW_RST =
    '{3'h0, 1'b0, 2'h3, 1'b1, 21'h0, 4'hf};
  localparam unit_sel_t UNIT_HW_RST = '{23'h0, 1'b1, 4'h0, 4'hf};

endpackage

// ---- verilog/cam_validity_init_control.sv ----
`timescale 1ns/10ps
// Operation
// - Mark-valid op with write low clears the pointed validity bit.
// - Same op with write high drives pointed validity on data bit 0.
// - Mark-empty op sets the pointed validity bit high.
// - Empty-top op empties the top match, only in its device.
// - Empty-every op empties all matched locations in every selected device.
// - Rank load copies data 3..0 into setup rank, then drives full low.
// - Clear-full op returns the full indication high in every device whose array is not full.
// - Software reset op; page and active outputs show all ones, active bit 12 zero on 4K.
// - Step-up op adds one to the location pointer.
// - Step-down op subtracts one from the location pointer.
// - Both resets empty the array and clear pointer and datapath.
// - After reset status shows flags 111, type 11, page 1111.
// - After reset active field is all ones, bit 12 zero on 4K.
// - Hardware reset loads setup and unit defaults; soft keeps setup and unit number, sets select disable.
// - Status bits 30, 29, 28 hold match, multi-match, full flags.
module cam_validity_init_control
  import cam_ctl_pkg::*;
#(
  parameter bit small_variant_p = 1'b0
) (
  input  wire logic            clock_i,
  input  wire logic            rst_i,
  input  wire logic [11:0]     op_i,
  input  wire logic            write_n_i,
  input  wire logic            address_valid_n_i,
  input  wire logic            half_select_i,
  input  wire logic [DW-1:0]   dq_i,
  input  wire logic            full_in_n_i,
  input  wire logic            top_match_in_n_i,
  input  wire logic [NLOC-1:0] match_vec_i,
  input  wire logic [AW-1:0]   top_match_addr_i,
  input  wire logic            top_match_hit_i,
  input  wire logic            match_n_i,
  input  wire logic            multi_match_n_i,
  input  wire logic            compare_done_i,
  input  wire logic [3:0]      reg_addr_i,
  input  wire logic [DW-1:0]   reg_wdata_i,
  input  wire logic            reg_wr_i,
  input  wire logic            reg_rd_i,
  output logic      [DW-1:0]   reg_rdata_o,
  output logic      [DW-1:0]   dq_o,
  output logic                 dq_oe_o,
  output logic                 full_flag_n_o,
  output logic      [RW-1:0]   page_o,
  output logic      [AW-1:0]   active_o,
  output logic                 soft_reset_o
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  localparam logic [AW-1:0] ACTIVE_RST =
    small_variant_p ? ACTIVE_4K : ACTIVE_ONES;

  logic [NLOC-1:0] empty_reg;
  logic [AW-1:0]   ptr_reg;
  setup_t          setup_reg;
  unit_sel_t       unit_reg;
  logic            forced_full_reg;
  logic            match_n_reg;
  logic            multi_n_reg;
  logic [1:0]      type_reg;
  logic [OPW-1:0]  op;
  logic            wcmd;
  logic            rcmd;
  logic            sel;
  logic            sw_rst;
  logic            any_rst;
  logic            cur_empty;
  logic [RW-1:0]   dq_rank;
  logic            mark_valid_go;
  logic            mark_empty_go;
  logic            empty_top_go;
  logic            empty_all_go;
  logic            load_go;
  logic            clear_go;
  logic            up_go;
  logic            down_go;
  logic            read_go;
  logic            ptr_op;
  unit_sel_t       unit_wr;

  assign op      = op_i[OPW-1:0];
  assign wcmd    = address_valid_n_i & ~half_select_i & ~write_n_i;
  assign rcmd    = address_valid_n_i & ~half_select_i & write_n_i;
  assign sel     = unit_reg.sel_dis | (unit_reg.unit == setup_reg.rank);
  assign sw_rst  = wcmd & (op == OP_SOFT_RESET);
  assign any_rst = rst_i | sw_rst;
  assign cur_empty = empty_reg[ptr_reg];
  assign dq_rank   = dq_i[RW-1:0];
  assign unit_wr   = reg_wdata_i;

  assign mark_valid_go = wcmd & sel & (op == OP_MARK_VALID);
  assign mark_empty_go = wcmd & sel & (op == OP_MARK_EMPTY);
  // Only the device holding the overall top match may act.
  assign empty_top_go  = wcmd & sel & (op == OP_EMPTY_TOP)
                         & top_match_hit_i & top_match_in_n_i;
  assign empty_all_go  = wcmd & sel & (op == OP_EMPTY_ALL);
  // A full upstream device passes the load down the chain.
  // Once loaded, the device refuses further loads until its full
  // indication is cleared, so back-to-back loads reach the next device.
  assign load_go       = wcmd & (op == OP_LOAD_RANK) & ~forced_full_reg
                         & ~full_in_n_i & full_flag_n_o;
  assign clear_go      = wcmd & (op == OP_CLEAR_FULL);
  assign up_go         = wcmd & sel & (op == OP_STEP_UP);
  assign down_go       = wcmd & sel & (op == OP_STEP_DOWN);
  assign read_go       = rcmd & sel & (op == OP_MARK_VALID);
  assign ptr_op        = mark_valid_go | mark_empty_go | read_go;

  // ----------------------------------------------------------------
  // Validity array
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (any_rst) begin
      empty_reg <= '1;
    end else if (mark_valid_go) begin
      empty_reg[ptr_reg] <= 1'b0;
    end else if (mark_empty_go) begin
      empty_reg[ptr_reg] <= 1'b1;
    end else if (empty_top_go) begin
      empty_reg[top_match_addr_i] <= 1'b1;
    end else if (empty_all_go) begin
      empty_reg <= empty_reg | match_vec_i;
    end
  end

  // ----------------------------------------------------------------
  // Location pointer
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (any_rst) begin
      ptr_reg <= PTR_RST;
    end else if (up_go) begin
      ptr_reg <= ptr_reg + PTR_ONE;
    end else if (down_go) begin
      ptr_reg <= ptr_reg - PTR_ONE;
    end else if (reg_wr_i && reg_addr_i == OFF_POINTER) begin
      ptr_reg <= reg_wdata_i[AW-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Setup and unit select
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      setup_reg <= SETUP_HW_RST;
    end else if (load_go) begin
      setup_reg.rank <= dq_rank;
    end else if (reg_wr_i && reg_addr_i == OFF_SETUP && !sw_rst) begin
      setup_reg          <= reg_wdata_i;
      setup_reg.rsvd28   <= 1'b0;
      setup_reg.rsvd     <= '0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      unit_reg <= UNIT_HW_RST;
    end else if (sw_rst) begin
      unit_reg.sel_dis <= 1'b1;
    end else if (reg_wr_i && reg_addr_i == OFF_UNIT) begin
      unit_reg.sel_dis <= unit_wr.sel_dis;
      unit_reg.unit    <= unit_wr.unit;
    end
  end

  // ----------------------------------------------------------------
  // Full indication
  // ----------------------------------------------------------------
  // The flag follows one cycle after the forcing state, so a full
  // array and a forced load both reach the pin through one flop.
  always_ff @(posedge clock_i) begin
    if (any_rst || clear_go) begin
      forced_full_reg <= 1'b0;
    end else if (load_go) begin
      forced_full_reg <= 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (any_rst) begin
      full_flag_n_o <= 1'b1;
    end else begin
      full_flag_n_o <= ~(forced_full_reg | ~|empty_reg);
    end
  end

  // ----------------------------------------------------------------
  // Status fields and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (any_rst) begin
      match_n_reg <= 1'b1;
      multi_n_reg <= 1'b1;
    end else if (compare_done_i) begin
      match_n_reg <= match_n_i;
      multi_n_reg <= multi_match_n_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (any_rst) begin
      type_reg <= TYPE_RESET;
      page_o   <= PAGE_ONES;
      active_o <= ACTIVE_RST;
    end else if (ptr_op) begin
      type_reg <= TYPE_MEMORY;
      page_o   <= setup_reg.rank;
      active_o <= ptr_reg;
    end else if (empty_top_go || empty_all_go || compare_done_i) begin
      type_reg <= TYPE_MATCH;
      page_o   <= setup_reg.rank;
      active_o <= top_match_addr_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i || !read_go) begin
      dq_o    <= '0;
      dq_oe_o <= 1'b0;
    end else begin
      dq_o    <= DW'(cur_empty);
      dq_oe_o <= 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    soft_reset_o <= rst_i ? 1'b0 : sw_rst;
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  status_t status;

  always_comb begin
    status           = '0;
    status.match_n   = match_n_reg;
    status.multi_n   = multi_n_reg;
    status.full_n    = full_flag_n_o;
    status.addr_type = type_reg;
    status.page      = page_o;
    status.active    = active_o;
  end

  always_ff @(posedge clock_i) begin
    if (rst_i || !reg_rd_i) begin
      reg_rdata_o <= '0;
    end else begin
      unique case (reg_addr_i)
        OFF_SETUP:   reg_rdata_o <= setup_reg;
        OFF_STATUS:  reg_rdata_o <= status;
        OFF_UNIT:    reg_rdata_o <= unit_reg;
        OFF_POINTER: reg_rdata_o <= DW'(ptr_reg);
        default:     reg_rdata_o <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  sequence s_load;
    load_go && !sw_rst;
  endsequence
  sequence s_quiet;
    !clear_go && !sw_rst && !(reg_wr_i && reg_addr_i == OFF_SETUP);
  endsequence

  a_mark_valid: assert property (
    mark_valid_go |=> !empty_reg[$past(ptr_reg)])
    else $error("mark valid left location empty");
  a_read_drive: assert property (
    read_go |=> dq_oe_o && dq_o[0] == $past(cur_empty)
      && dq_o[DW-1:1] == '0)
    else $error("validity read data wrong");
  a_every_match: assert property (
    empty_all_go && !sw_rst |=>
      (empty_reg & $past(match_vec_i)) == $past(match_vec_i))
    else $error("matched location still valid");
  a_rank_full: assert property (
    s_load ##1 s_quiet |=> !full_flag_n_o
      && setup_reg.rank == $past(dq_rank, 2))
    else $error("rank load did not take effect");
  a_full_clear: assert property (
    clear_go ##1 (!load_go && |empty_reg) |=> full_flag_n_o)
    else $error("full indication not cleared");
  a_soft_reset: assert property (
    sw_rst |=> page_o == PAGE_ONES && active_o == ACTIVE_RST
      && ptr_reg == PTR_RST && &empty_reg && soft_reset_o)
    else $error("soft reset values wrong");
  a_setup_keep: assert property (
    sw_rst |=> setup_reg == $past(setup_reg))
    else $error("soft reset changed setup");
  a_step_up: assert property (
    up_go && !sw_rst |=> ptr_reg == $past(ptr_reg) + PTR_ONE)
    else $error("pointer did not step up");
  a_step_down: assert property (
    down_go && !sw_rst |=> ptr_reg == $past(ptr_reg) - PTR_ONE)
    else $error("pointer did not step down");

endmodule
